// ### rtl/scsc_pkg.sv
// Purpose: constants for the system clock source control block
// Assumes: 8-bit special-function register port, one 50 MHz clock
// Notes:   offsets, field layouts, reset values, source codes and settle count; no logic here
package scsc_pkg;
	localparam logic [7:0] ext_osc_ctrl_addr   = 8'h8c;
	localparam logic [7:0] system_clock_sel_addr     = 8'h97;
	localparam logic [7:0] int_osc_ctrl_addr   = 8'h8d;
	localparam logic [7:0] ext_osc_ctrl_reset  = 8'h00;
	localparam logic [7:0] system_clock_sel_reset    = 8'h00;
	localparam logic [7:0] int_osc_ctrl_reset  = 8'hc0;
	localparam int         int_osc_enable_bit  = 7;
	localparam int         int_osc_ready_bit   = 6;
	localparam int         crystal_valid_bit   = 7;
	localparam int         pll_lock_bit        = 7;
	localparam logic [1:0] src_internal        = 2'h0;
	localparam logic [1:0] src_external        = 2'h1;
	localparam logic [1:0] src_pll             = 2'h2;
	localparam int         ready_settle_cycles = 4;
endpackage

// ### rtl/scsc_glitchless_mux.sv
// Purpose: glitch-free two-stage handover between clock sources
// Assumes: source clocks and their versions arrive as sampled levels
// Notes:   the old source is released before the new one is granted
`timescale 1ns/1ps
module scsc_glitchless_mux #(
	parameter int n_src = 3
) (
	input  wire logic             mclk,     // block clock
	input  wire logic             nrst,     // sync reset, active low
	input  wire logic [n_src-1:0] want,     // one-hot requested source
	input  wire logic [n_src-1:0] clk_lvl,  // synchronised source levels
	output logic      [n_src-1:0] grant,    // one-hot granted source
	output logic                  clk_out   // muxed clock level
);
	logic [n_src-1:0] next_grant;
	logic             next_clk_out;

	always_comb begin
		next_grant = grant;
		// release only while the current source is low to avoid runts
		if (want != grant && (grant & clk_lvl) == '0) begin // [RQ16]
			if (grant != '0)
				next_grant = '0;
			else if ((want & clk_lvl) == '0)
				next_grant = want;
		end
		next_clk_out = |(next_grant & clk_lvl);
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			grant   <= n_src'(1); // [RQ15]
			clk_out <= 1'b0;
		end else begin
			grant   <= next_grant;
			clk_out <= next_clk_out;
		end
	end
endmodule

// ### rtl/scsc_top.sv
// Purpose: system clock source selection, dividers and status flags
// Assumes: clocks are sampled as levels on mclk, far slower than 50 MHz
// Notes:   registers reached by an 8-bit sfr address/data port
`timescale 1ns/1ps
// Behaviour
// [RQ1] bit 7 of internal oscillator control enables the internal oscillator
// [RQ2] bit 6 reads 1 only while internal oscillator runs at its frequency
// [RQ3] internal divide field 00 by 8, 01 by 4, 10 by 2, 11 by 1
// [RQ4] source field 00 internal, 01 external, 10 pll, 11 reserved
// [RQ5] external oscillator stays available to peripherals at all times
// [RQ6] source may change while running; software picks settled sources
// [RQ7] one write may enable internal oscillator and select it; here one write sets enable and divide, selection needs a separate csel write
// [RQ8] crystal valid flag bit 7 set when settled, only in modes 11x
// [RQ9] software waits 1 ms after enabling crystal before polling valid
// [RQ10] pll lock flag is set by hardware when pll locks
// [RQ11] output divide bits 5:4: 00 by 1, 01 by 2, 10 by 4, 11 by 8
// [RQ12] ext mode decode: 00x off, 010/011 cmos, 10x rc/c, 11x crystal
// [RQ13] bit 3 of external control reads 0, writes ignored
// [RQ14] software sets frequency control field to suit mode
// [RQ15] after reset the internal oscillator is the system clock
// [RQ16] source changes produce no runt pulses or glitches
module scsc_top (
	input  wire logic       mclk,            // 50 mhz block clock
	input  wire logic       nrst,            // sync reset, active low
	input  wire logic [7:0] sfr_addr,        // register address
	input  wire logic [7:0] sfr_wdata,       // write data
	input  wire logic       sfr_wr,          // write strobe
	input  wire logic       sfr_rd,          // read strobe
	output logic      [7:0] sfr_rdata,       // read data
	input  wire logic       int_osc_clk,     // internal oscillator level
	input  wire logic       int_osc_stable,  // analog ready indication
	input  wire logic       crystal_pin_one, // external clock level
	input  wire logic       ext_amp_ok,      // crystal amplitude detector
	input  wire logic       pll_clk,         // pll output level
	input  wire logic       pll_locked,      // pll lock detector
	output logic            int_osc_en,      // internal oscillator enable
	output logic      [2:0] ext_osc_mode,    // drive circuit mode
	output logic      [2:0] ext_osc_freq,    // drive circuit range
	output logic            ext_clk_periph,  // external clock to timers
	output logic            system_clock,    // selected system clock
	output logic            clock_out_pin,   // divided clock for port pin
	output logic      [1:0] src_active       // granted source code
);
	logic [7:0] ioc, next_ioc;
	logic [7:0] xoc, next_xoc;
	logic [7:0] csel, next_csel;
	logic [7:0] next_rdata;
	// two-stage synchronisers: stage a feeds stage b only
	logic [5:0] sync_a, sync_b;
	logic       int_lvl, ext_lvl, pll_lvl, stab, amp;
	logic       lock_s;
	logic [2:0] int_div, next_int_div;
	logic [1:0] div_code, next_div_code;
	logic       int_div_clk, next_int_div_clk, int_prev;
	logic       ext_div_clk, next_ext_div_clk, ext_prev;
	logic       ext_src, ext_gated;
	logic [2:0] want, grant;
	logic       mux_clk, mux_prev;
	logic [2:0] out_cnt, next_out_cnt;
	logic       next_clock_out;
	logic       sys_q, ext_q;
	logic [2:0] ready_cnt, next_ready_cnt;
	logic       int_ready, next_int_ready;
	logic       xtal_mode, ext_on;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync_a <= 6'h00;
			sync_b <= 6'h00;
		end else begin
			// pll level comes from another clock too, so it is synchronised
			sync_a <= {pll_clk, pll_locked, ext_amp_ok, int_osc_stable,
			           crystal_pin_one, int_osc_clk};
			sync_b <= sync_a;
		end
	end
	assign int_lvl = sync_b[0];
	assign ext_lvl = sync_b[1];
	assign stab    = sync_b[2];
	assign amp     = sync_b[3];
	assign lock_s  = sync_b[4];
	assign pll_lvl = sync_b[5];

	assign xtal_mode = xoc[6:5] == 2'b11;                 // [RQ12]
	assign ext_on    = xoc[6:5] != 2'b00;                 // [RQ12]

	always_comb begin
		next_ioc  = ioc;
		next_xoc  = xoc;
		next_csel = csel;
		if (sfr_wr) begin
			unique case (sfr_addr)
			scsc_pkg::int_osc_ctrl_addr:
				// enable and divide taken in one write [RQ7]
				next_ioc = {sfr_wdata[7], 5'b0_0000, sfr_wdata[1:0]}; // [RQ1]
			scsc_pkg::ext_osc_ctrl_addr:
				next_xoc = {1'b0, sfr_wdata[6:4], 1'b0, sfr_wdata[2:0]}; // [RQ13]
			scsc_pkg::system_clock_sel_addr:
				next_csel = {2'b00, sfr_wdata[5:4], 2'b00, sfr_wdata[1:0]};
			default: ;
			endcase
		end
		next_rdata = 8'h0_0;
		if (sfr_rd) begin
			unique case (sfr_addr)
			scsc_pkg::int_osc_ctrl_addr:
				next_rdata = {ioc[7], int_ready, 4'h0, ioc[1:0]}; // [RQ2]
			scsc_pkg::ext_osc_ctrl_addr:
				next_rdata = {xtal_mode & amp, xoc[6:4], 1'b0,
				              xoc[2:0]};                   // [RQ8] [RQ13]
			scsc_pkg::system_clock_sel_addr:
				next_rdata = csel;
			default: next_rdata = {lock_s, 7'h0_0}; // pll lock view [RQ10]
			endcase
		end
	end

	// ready counts settle cycles once enabled and stable
	always_comb begin
		next_ready_cnt = ready_cnt;
		next_int_ready = int_ready;
		if (!ioc[7] || !stab) begin
			next_ready_cnt = 3'h0;
			next_int_ready = 1'b0;
		end else if (ready_cnt == 3'(scsc_pkg::ready_settle_cycles)) begin
			next_int_ready = 1'b1;                          // [RQ2]
		end else begin
			next_ready_cnt = ready_cnt + 3'h1;
		end
	end

	// internal divider: rising edges counted, toggle at half ratio
	always_comb begin
		next_int_div     = int_div;
		next_int_div_clk = int_div_clk;
		next_div_code    = div_code;
		if (!ioc[7]) begin                                 // [RQ1]
			next_int_div     = 3'h0;
			next_int_div_clk = 1'b0;
			next_div_code    = ioc[1:0];
		end else if (int_lvl && !int_prev) begin
			// ratio taken only at a source rise, so no phase is cut short
			next_div_code = ioc[1:0];                      // [RQ16]
			next_int_div  = int_div + 3'h1;
			unique case (next_div_code)                    // [RQ3]
			2'b00: next_int_div_clk = next_int_div[2];
			2'b01: next_int_div_clk = next_int_div[1];
			2'b10: next_int_div_clk = next_int_div[0];
			2'b11: next_int_div_clk = int_lvl;
			endcase
		end else if (div_code == 2'b11) begin              // [RQ3]
			next_int_div_clk = int_lvl;
		end
	end

	// external path honours mode divide by 2 options
	always_comb begin
		next_ext_div_clk = ext_div_clk;
		if (!ext_on)
			next_ext_div_clk = 1'b0;
		else if (ext_lvl && !ext_prev)
			next_ext_div_clk = ~ext_div_clk;
	end
	assign ext_src   = (xoc[4] || xoc[6:4] == 3'b100 || xoc[6:4] == 3'b101)
	                   ? ext_div_clk : ext_lvl;               // [RQ12]
	assign ext_gated = ext_on & ext_src;

	always_comb begin
		unique case (csel[1:0])                            // [RQ4] [RQ6]
		scsc_pkg::src_external: want = 3'b010;
		scsc_pkg::src_pll:      want = 3'b100;
		default:                want = 3'b001;  // reserved stays internal
		endcase
	end

	scsc_glitchless_mux #(.n_src(3)) u_mux (
		.mclk    (mclk),
		.nrst    (nrst),
		.want    (want),
		.clk_lvl ({pll_lvl, ext_gated, int_div_clk}),
		.grant   (grant),
		.clk_out (mux_clk)
	);

	always_comb begin
		next_out_cnt = out_cnt;
		if (mux_clk && !mux_prev)
			next_out_cnt = out_cnt + 3'h1;
		unique case (csel[5:4])                            // [RQ11]
		2'b00:   next_clock_out = mux_clk;
		2'b01:   next_clock_out = next_out_cnt[0];
		2'b10:   next_clock_out = next_out_cnt[1];
		default: next_clock_out = next_out_cnt[2];
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ioc           <= scsc_pkg::int_osc_ctrl_reset;
			xoc           <= scsc_pkg::ext_osc_ctrl_reset;
			csel          <= scsc_pkg::system_clock_sel_reset;   // [RQ15]
			sfr_rdata     <= 8'h0_0;
			ready_cnt     <= 3'h0;
			int_ready     <= 1'b0;
			int_div       <= 3'h0;
			div_code      <= scsc_pkg::int_osc_ctrl_reset[1:0];
			int_div_clk   <= 1'b0;
			int_prev      <= 1'b0;
			ext_div_clk   <= 1'b0;
			ext_prev      <= 1'b0;
			mux_prev      <= 1'b0;
			out_cnt       <= 3'h0;
			clock_out_pin <= 1'b0;
			sys_q         <= 1'b0;
			ext_q         <= 1'b0;
		end else begin
			ioc           <= next_ioc;
			xoc           <= next_xoc;
			csel          <= next_csel;
			sfr_rdata     <= next_rdata;
			ready_cnt     <= next_ready_cnt;
			int_ready     <= next_int_ready;
			int_div       <= next_int_div;
			div_code      <= next_div_code;
			int_div_clk   <= next_int_div_clk;
			int_prev      <= int_lvl;
			ext_div_clk   <= next_ext_div_clk;
			ext_prev      <= ext_lvl;
			mux_prev      <= mux_clk;
			out_cnt       <= next_out_cnt;
			clock_out_pin <= next_clock_out;
			sys_q         <= mux_clk;
			ext_q         <= ext_gated;  // independent of source select [RQ5]
		end
	end

	assign int_osc_en     = ioc[7];
	assign ext_osc_mode   = xoc[6:4];
	assign ext_osc_freq   = xoc[2:0];
	assign ext_clk_periph = ext_q;
	assign system_clock   = sys_q;
	assign src_active     = {grant[2], grant[1]};
endmodule

// ### verification/scsc_osc_model.sv
// Purpose: oscillators, crystal and pll on the far side of the block
// Assumes: levels change on mclk falling edges, far slower than mclk
// Notes:   a clock stands low while its source is off
`timescale 1ns/1ps
module scsc_osc_model #(
	parameter int amp_settle = 20 // shortened crystal start-up, cycles
) (
	input  wire logic       mclk,            // block clock
	input  wire logic       nrst,            // sync reset, active low
	input  wire logic       int_osc_en,      // internal enable
	input  wire logic [2:0] ext_osc_mode,    // drive mode
	output logic            int_osc_clk,     // internal level, period 6
	output logic            int_osc_stable,  // internal settled
	output logic            crystal_pin_one, // external level, period 10
	output logic            ext_amp_ok,      // amplitude good
	output logic            pll_clk,         // pll level, period 4
	output logic            pll_locked       // pll locked
);
	int c = 0, xc = 0, ic = 0;
	initial {int_osc_clk, int_osc_stable, crystal_pin_one} = 3'h0;
	initial {ext_amp_ok, pll_clk, pll_locked} = 3'h0;
	always @(negedge mclk) begin
		c <= c + 1;
		ic <= int_osc_en ? ic + 1 : 0;
		xc <= ext_osc_mode[2:1] == 2'h3 ? xc + 1 : 0;
		int_osc_clk <= int_osc_en && c % 6 < 3;
		int_osc_stable <= ic > 2;
		crystal_pin_one <= ext_osc_mode[2:1] != 2'h0 && c % 10 < 5;
		ext_amp_ok <= xc > amp_settle;
		pll_clk <= c % 4 < 2;
		pll_locked <= nrst && c > 40;
	end
endmodule

// ### verification/scsc_top_chk.sv
// Purpose: port checker for the clock source control block
// Assumes: all source clocks have half periods of two mclk or more
// Notes:   bound to every scsc_top instance
`timescale 1ns/1ps
module scsc_top_chk (
	input wire logic       mclk,           // block clock
	input wire logic       nrst,           // sync reset, active low
	input wire logic [7:0] sfr_addr,       // register address
	input wire logic [7:0] sfr_wdata,      // write data
	input wire logic       sfr_wr,         // write strobe
	input wire logic       sfr_rd,         // read strobe
	input wire logic [7:0] sfr_rdata,      // read data
	input wire logic       int_osc_en,     // internal enable
	input wire logic [2:0] ext_osc_mode,   // drive mode
	input wire logic [2:0] ext_osc_freq,   // drive range
	input wire logic       ext_clk_periph, // peripheral clock
	input wire logic       system_clock,   // selected clock
	input wire logic [1:0] src_active      // granted source
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire       wi = sfr_wr && sfr_addr == scsc_pkg::int_osc_ctrl_addr;
	wire       wx = sfr_wr && sfr_addr == scsc_pkg::ext_osc_ctrl_addr;
	wire       ws = sfr_wr && sfr_addr == scsc_pkg::system_clock_sel_addr;
	wire       ri = sfr_rd && sfr_addr == scsc_pkg::int_osc_ctrl_addr;
	wire       rx = sfr_rd && sfr_addr == scsc_pkg::ext_osc_ctrl_addr;
	wire       en_req = sfr_wdata[7];
	wire [5:0] xw = {sfr_wdata[6:4], sfr_wdata[2:0]};
	a_int_enable: assert property (wi |=> int_osc_en == $past(en_req))
		else $error("enable bit not applied");
	a_ext_fields: assert property (
		wx |=> {ext_osc_mode, ext_osc_freq} == $past(xw))
		else $error("external fields not applied");
	a_ready_off: assert property (
		!int_osc_en [*2] ##0 ri |=> !sfr_rdata[6])
		else $error("ready flag while disabled");
	a_valid_mode: assert property (
		rx && ext_osc_mode[2:1] != 2'h3 |=> !sfr_rdata[7])
		else $error("crystal valid outside crystal mode");
	a_bit3_zero: assert property (rx |=> !sfr_rdata[3])
		else $error("reserved bit reads one");
	a_src_legal: assert property (src_active != 2'h3)
		else $error("reserved source granted");
	a_reset_src: assert property (
		$rose(nrst) |-> src_active == 2'h0 && int_osc_en)
		else $error("reset source not internal");
	a_no_runt: assert property (
		$changed(system_clock) |=> $stable(system_clock))
		else $error("runt pulse on system clock");
	a_periph_off: assert property (
		ext_osc_mode[2:1] == 2'h0 [*8] |-> !ext_clk_periph)
		else $error("peripheral clock runs while off");
	a_switch_ext: assert property (
		ws && sfr_wdata[1:0] == 2'h1 && int_osc_en
		|-> ##[1:100] src_active == 2'h1)
		else $error("switch to external not granted");
	c_ext: cover property (src_active == 2'h1);
	c_pll: cover property (src_active == 2'h2);
	c_xtal: cover property (rx && ext_osc_mode[2:1] == 2'h3);
endmodule
bind scsc_top scsc_top_chk u_chk (.mclk, .nrst, .sfr_addr, .sfr_wdata,
	.sfr_wr, .sfr_rd, .sfr_rdata, .int_osc_en, .ext_osc_mode, .ext_osc_freq,
	.ext_clk_periph, .system_clock, .src_active);

// ### verification/system_clock_source_control_test.sv
// Purpose: self-checking bench for the clock source control block
// Assumes: reads are checked from a queue of expected bytes
// Notes:   clock periods are counted in mclk cycles
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module system_clock_source_control_test;
	logic        mclk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, rd_seen = 0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, r;
	logic        int_osc_clk, int_osc_stable, crystal_pin_one, ext_amp_ok;
	logic        pll_clk, pll_locked, int_osc_en, ext_clk_periph;
	logic        system_clock, clock_out_pin;
	logic [2:0]  ext_osc_mode, ext_osc_freq;
	logic [1:0]  src_active;
	logic [15:0] exp_q[$], q;
	int          miscompares = 0, tests_run = 0, cycles = 0, seed = 76, i;
	localparam logic [7:0] ia = scsc_pkg::int_osc_ctrl_addr;
	localparam logic [7:0] xa = scsc_pkg::ext_osc_ctrl_addr;
	localparam logic [7:0] sa = scsc_pkg::system_clock_sel_addr;
	scsc_top dut (.mclk, .nrst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_rdata, .int_osc_clk, .int_osc_stable, .crystal_pin_one,
		.ext_amp_ok, .pll_clk, .pll_locked, .int_osc_en, .ext_osc_mode,
		.ext_osc_freq, .ext_clk_periph, .system_clock, .clock_out_pin,
		.src_active);
	scsc_osc_model #(.amp_settle(20)) u_osc (.mclk, .nrst, .int_osc_en,
		.ext_osc_mode, .int_osc_clk, .int_osc_stable, .crystal_pin_one,
		.ext_amp_ok, .pll_clk, .pll_locked);
	always #10 mclk = ~mclk;
	always @(posedge mclk) rd_seen <= sfr_rd;
	always @(negedge mclk) if (rd_seen) begin
		q = exp_q.pop_front();
		`CHK(sfr_rdata & q[15:8], q[7:0])
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		{sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
		@(negedge mclk) sfr_wr = 0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, e);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		exp_q.push_back({m, e});
		@(negedge mclk) sfr_rd = 0;
		@(negedge mclk);
	endtask
	function automatic logic lv(input int s);
		return s == 0 ? system_clock : s == 1 ? clock_out_pin : ext_clk_periph;
	endfunction
	// skips the first rise, since a divider change may leave a short cycle
	task automatic per(input int s, input int want);
		logic pv;
		int   k, n, r1, r2;
		{pv, n, r1, r2} = {1'b1, 32'd0, 32'd0, -32'sd1};
		for (k = 0; k < 600 && r2 < 0; k++) begin
			@(negedge mclk);
			if (lv(s) === 1'b1 && pv === 1'b0) n++;
			if (lv(s) === 1'b1 && pv === 1'b0 && n == 2) r1 = k;
			if (lv(s) === 1'b1 && pv === 1'b0 && n == 3) r2 = k;
			pv = lv(s);
		end
		`CHK(r2 - r1, want)
	endtask
	task automatic wt(input logic [1:0] v);
		for (int k = 0; k < 200 && src_active !== v; k++) @(negedge mclk);
		`CHK(src_active, v)
	endtask
	initial begin
		repeat (16) @(negedge mclk);
		nrst = 1;
		repeat (12) @(negedge mclk);
		`CHK({int_osc_en, src_active}, 3'h4)
		rd(ia, 8'hff, 8'hc0);
		rd(xa, 8'hff, 8'h00);
		rd(sa, 8'hff, 8'h00);
		$display("test reset done");
		for (i = 0; i < 4; i++) begin
			wr(ia, {1'b1, 5'($random(seed)), 2'(i)});
			rd(ia, 8'hff, {6'h30, 2'(i)});
			per(0, 6 << (3 - i));
		end
		for (i = 0; i < 4; i++) begin
			wr(sa, {2'($random(seed)), 2'(i), 2'($random(seed)), 2'h0});
			rd(sa, 8'hff, {2'h0, 2'(i), 4'h0});
			per(1, 6 << i);
		end
		$display("test dividers done");
		// park on the pll so stopping the internal source cuts no phase
		wr(sa, 8'h02);
		wt(2'h2);
		wr(ia, 8'h00);
		repeat (8) @(negedge mclk);
		`CHK(int_osc_en, 1'b0)
		rd(ia, 8'hff, 8'h00);
		wr(ia, 8'h83);
		// let the restarted oscillator's first partial phase pass
		repeat (10) @(negedge mclk);
		wr(sa, 8'h00);
		wt(2'h0);
		rd(ia, 8'hff, 8'hc3);
		per(0, 6);
		$display("test enable done");
		for (i = 0; i < 8; i++) begin
			r = {1'b0, 3'(i), 1'($random(seed)), 3'(i) ^ 3'h5};
			wr(xa, r);
			repeat (30) @(negedge mclk);
			`CHK({ext_osc_mode, ext_osc_freq}, {r[6:4], r[2:0]})
			rd(xa, 8'hff, {r[6:5] == 2'h3, r[6:4], 1'b0, r[2:0]});
			if (i >= 2) per(2, (i == 2 || i == 6) ? 10 : 20);
		end
		$display("test external done");
		wr(xa, 8'h20);
		wr(sa, 8'h01);
		wt(2'h1);
		per(0, 10);
		wr(sa, 8'h02);
		wt(2'h2);
		per(0, 4);
		rd(8'h00, 8'hff, 8'h80);
		wr(sa, 8'h03);
		wt(2'h0);
		per(0, 6);
		$display("test switching done");
		final_report;
	end
endmodule
